/* File: hdl/ucif_top.sv */
// Interrupt unit and queue control for one serial channel, AHB-Lite slave.
// Behaviour
// - Tx ready follows holding-empty when direction control off
// - Tx ready follows all-empty when direction control on
// - Errored received character raises line status
// - Enable bits 5-7 need gate bit
// - Status shows highest pending, others wait
// - Fixed six-bit codes in priority order
// - Timeout after four chars plus twelve bits
// - Receive ready tracks level against trigger
// - Line and modem reads clear their sources
// - Status read clears tx and flow-char
// - Special match clears on status read or next char
// - Modem irq on modem bits 0-3
// - Flow input rising edge with auto input
// - Flow output rising edge with auto output
// - Wake flag set leaving sleep, global read clears
// - Status bit 0 is one when idle
// - Status bit 4 gated, last Xon/Xoff indicator
// - Status bits 7:6 show queue enable
// - Queue enable bit gates other control bits
// - Queue resets pulse then self-clear
// - Block mode bit stored, no effect
// - Tx trigger event on falling below trigger
// - Receive ready uses holding slot outside queue mode
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ucif_top
    import ucif_pkg::*;
(
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Channel state from the datapath.
    input  wire logic [7:0]  line_state_reg,
    input  wire logic [7:0]  modem_state_reg,
    input  wire logic        rx_char_push,
    input  wire logic        rx_active,
    input  wire logic        bit_tick,
    input  wire logic [3:0]  char_bits,
    input  wire logic [6:0]  rx_level,
    input  wire logic [6:0]  rx_trig,
    input  wire logic [6:0]  tx_level,
    input  wire logic [6:0]  tx_trig,
    input  wire logic        xon_det,
    input  wire logic        xoff_det,
    input  wire logic        special_det,
    input  wire logic        flow_in_cts,
    input  wire logic        flow_in_dsr,
    input  wire logic        flow_out_rts,
    input  wire logic        flow_out_dtr,
    input  wire logic        sleep_active,
    // Control toward the datapath.
    output logic             fifo_en,
    output logic             rx_fifo_reset,
    output logic             tx_fifo_reset,
    output logic             block_mode,
    output logic [1:0]       tx_trig_sel,
    output logic [1:0]       rx_trig_sel,
    output logic [1:0]       trig_table,
    output logic             auto_dir,
    output logic             auto_out,
    output logic             auto_in,
    output logic             pin_sel,
    // Indications.
    output logic             wake_ind,
    output logic             irq
);

    ucif_prio_if pif ();

    logic [7:0]  enable_r;
    logic [7:0]  feature_r;
    logic        dph_r;
    logic        done_r;
    logic        dwr_r;
    logic [7:0]  daddr_r;
    logic        line_irq_r;
    logic        tx_irq_r;
    logic        modem_irq_r;
    logic        flow_char_indicator_irq_r;
    logic        special_irq_r;
    logic        fin_irq_r;
    logic        fout_irq_r;
    logic        wake_r;
    logic [1:0]  flow_char_r;
    logic [6:0]  tmo_cnt_r;
    logic        tmo_irq_r;
    logic        lsr5_q_r;
    logic        lsr6_q_r;
    logic [3:0]  msr_q_r;
    logic        fin_q_r;
    logic        fout_q_r;
    logic        sleep_q_r;
    logic [6:0]  tx_level_q_r;
    logic        tx_over_r;
    logic        act;
    logic        wr_act;
    logic        rd_act;
    logic        rd_status;
    logic        rd_line;
    logic        rd_modem;
    logic        rd_global;
    logic        rd_flowchar;
    logic        gate;
    logic [7:0]  en_eff;
    logic        rx_ready;
    logic        tx_event;
    logic        fin_sel;
    logic        fout_sel;
    logic [6:0]  tmo_limit;
    logic [5:0]  code;
    logic [7:0]  status_val;
    logic [31:0] rdata;

    ucif_prio u_prio (
        .pif (pif.enc)
    );

    // Bus data phase: one wait cycle, then the registered answer.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_r   <= 1'b0;
            done_r  <= 1'b0;
            dwr_r   <= 1'b0;
            daddr_r <= 8'h00;
        end else if (hsel && htrans[1] && hready) begin
            dph_r   <= 1'b1;
            done_r  <= 1'b0;
            dwr_r   <= hwrite;
            daddr_r <= {haddr[7:2], 2'b00};
        end else if (dph_r && !done_r) begin
            done_r <= 1'b1;
        end else if (hready) begin
            dph_r  <= 1'b0;
            done_r <= 1'b0;
        end
    end

    assign hreadyout = !(dph_r && !done_r);
    assign hresp     = 1'b0;

    // The access acts once, in the wait cycle, with hwdata already valid.
    assign act         = dph_r && !done_r;
    assign wr_act      = act && dwr_r;
    assign rd_act      = act && !dwr_r;
    assign rd_status   = rd_act && (daddr_r == OFS_STATUS);
    assign rd_line     = rd_act && (daddr_r == OFS_LINE);
    assign rd_modem    = rd_act && (daddr_r == OFS_MODEM);
    assign rd_global   = rd_act && (daddr_r == OFS_GLOBAL);
    assign rd_flowchar = rd_act && (daddr_r == OFS_FLOWCHAR);

    // Read data is latched in the wait cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_act) begin
            hrdata <= rdata;
        end
    end

    // Read mux; unmapped and write-only offsets read as zero.
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (daddr_r)
            OFS_ENABLE:   rdata[7:0] = enable_r;
            OFS_STATUS:   rdata[7:0] = status_val;
            OFS_FEATURE:  rdata[7:0] = feature_r;
            OFS_FLOWCHAR: rdata[1:0] = flow_char_r;
            OFS_LINE:     rdata[7:0] = line_state_reg;
            OFS_MODEM:    rdata[7:0] = modem_state_reg;
            OFS_GLOBAL:   rdata[0]   = wake_r;
            default:      rdata      = 32'h0000_0000;
        endcase
    end

    // Enable and feature registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_r  <= ENABLE_RST;
            feature_r <= FEATURE_RST;
        end else if (wr_act) begin
            if (daddr_r == OFS_ENABLE) begin
                enable_r <= hwdata[7:0];
            end
            if (daddr_r == OFS_FEATURE) begin
                feature_r <= hwdata[7:0];
            end
        end
    end

    assign gate       = feature_r[FT_GATE];
    assign trig_table = feature_r[FT_TBL_HI:FT_TBL_LO];
    assign auto_dir   = feature_r[FT_AUTO_DIR];
    assign auto_out   = feature_r[FT_AUTO_OUT];
    assign auto_in    = feature_r[FT_AUTO_IN];
    assign pin_sel    = feature_r[FT_PIN_SEL];

    // Upper enables count only behind the gate bit.
    assign en_eff = {enable_r[7:5] & {3{gate}}, 1'b0, enable_r[3:0]};

    // Queue control: bit 0 in the same write unlocks the rest; the transmit trigger also needs the gate bit.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fifo_en       <= 1'b0;
            rx_fifo_reset <= 1'b0;
            tx_fifo_reset <= 1'b0;
            block_mode    <= 1'b0;
            tx_trig_sel   <= 2'b00;
            rx_trig_sel   <= 2'b00;
        end else begin
            rx_fifo_reset <= 1'b0;
            tx_fifo_reset <= 1'b0;
            if (wr_act && (daddr_r == OFS_QCTRL)) begin
                fifo_en <= hwdata[QC_EN];
                if (hwdata[QC_EN]) begin
                    rx_fifo_reset <= hwdata[QC_RXRST];
                    tx_fifo_reset <= hwdata[QC_TXRST];
                    block_mode    <= hwdata[QC_MODE];
                    rx_trig_sel   <= hwdata[QC_RXT_HI:QC_RXT_LO];
                    if (gate) begin
                        tx_trig_sel <= hwdata[QC_TXT_HI:QC_TXT_LO];
                    end
                end
            end
        end
    end

    // Edge history for the event sources.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lsr5_q_r     <= 1'b1;
            lsr6_q_r     <= 1'b1;
            msr_q_r      <= 4'h0;
            fin_q_r      <= 1'b0;
            fout_q_r     <= 1'b0;
            sleep_q_r    <= 1'b0;
            tx_level_q_r <= 7'h00;
        end else begin
            lsr5_q_r     <= line_state_reg[LS_THR_E];
            lsr6_q_r     <= line_state_reg[LS_ALL_E];
            msr_q_r      <= modem_state_reg[3:0];
            fin_q_r      <= fin_sel;
            fout_q_r     <= fout_sel;
            sleep_q_r    <= sleep_active;
            tx_level_q_r <= tx_level;
        end
    end

    // Whether the last transmit reload went over the trigger.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_over_r <= 1'b0;
        end else if (tx_level == 7'h00) begin
            tx_over_r <= 1'b0;
        end else if (tx_level > tx_trig) begin
            tx_over_r <= 1'b1;
        end
    end

    // Transmit ready events, chosen by the direction control mode.
    always_comb begin
        if (auto_dir) begin
            tx_event = line_state_reg[LS_ALL_E] && !lsr6_q_r;
        end else begin
            tx_event = (line_state_reg[LS_THR_E] && !lsr5_q_r)
                     || (fifo_en && (tx_level < tx_trig) && (tx_level_q_r >= tx_trig))
                     || (fifo_en && !tx_over_r && (tx_level == 7'h00) && (tx_level_q_r != 7'h00));
        end
    end

    // Transmit ready flag; only a read that reports it clears it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_irq_r <= 1'b0;
        end else if (tx_event) begin
            tx_irq_r <= 1'b1;
        end else if (rd_status && (code == CODE_TX)) begin
            tx_irq_r <= 1'b0;
        end
    end

    // Line status: errored push sets, line state read clears.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_irq_r <= 1'b0;
        end else if (rx_char_push && (|line_state_reg[4:1])) begin
            line_irq_r <= 1'b1;
        end else if (rd_line) begin
            line_irq_r <= 1'b0;
        end
    end

    // Modem status: a new delta bit sets, modem state read clears.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            modem_irq_r <= 1'b0;
        end else if (|(modem_state_reg[3:0] & ~msr_q_r)) begin
            modem_irq_r <= 1'b1;
        end else if (rd_modem) begin
            modem_irq_r <= 1'b0;
        end
    end

    // Flow pins selected by the pin select bit.
    assign fin_sel  = pin_sel ? flow_in_dsr : flow_in_cts;
    assign fout_sel = pin_sel ? flow_out_dtr : flow_out_rts;

    // Flow pin change flags; modem state read clears both.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fin_irq_r  <= 1'b0;
            fout_irq_r <= 1'b0;
        end else begin
            if (auto_in && fin_sel && !fin_q_r) begin
                fin_irq_r <= 1'b1;
            end else if (rd_modem) begin
                fin_irq_r <= 1'b0;
            end
            if (auto_out && fout_sel && !fout_q_r) begin
                fout_irq_r <= 1'b1;
            end else if (rd_modem) begin
                fout_irq_r <= 1'b0;
            end
        end
    end

    // Flow character flags and the last Xon/Xoff indicator.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flow_char_indicator_irq_r   <= 1'b0;
            special_irq_r <= 1'b0;
            flow_char_r   <= 2'b00;
        end else begin
            if (xon_det || xoff_det) begin
                flow_char_indicator_irq_r <= 1'b1;
            end else if (rd_status && (code == CODE_CHAR)) begin
                flow_char_indicator_irq_r <= 1'b0;
            end
            if (special_det) begin
                special_irq_r <= 1'b1;
            end else if ((rd_status && (code == CODE_CHAR)) || rx_char_push) begin
                special_irq_r <= 1'b0;
            end
            if (xon_det || xoff_det) begin
                flow_char_r <= {xon_det, xoff_det};
            end else if (rd_flowchar) begin
                flow_char_r <= 2'b00;
            end
        end
    end

    // Wake flag; only the global register read clears it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_r <= 1'b0;
        end else if (sleep_q_r && !sleep_active) begin
            wake_r <= 1'b1;
        end else if (rd_global) begin
            wake_r <= 1'b0;
        end
    end

    assign wake_ind = wake_r;

    // Receive ready: trigger in queue mode, holding slot otherwise.
    assign rx_ready = fifo_en ? (rx_level >= rx_trig) : line_state_reg[LS_READY];

    // Timeout in bit times: four characters plus twelve bits.
    assign tmo_limit = 7'((TMO_CHARS * char_bits)) + TMO_BITS;

    // Timeout counts idle bit times while data sits below trigger.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tmo_cnt_r <= 7'h00;
            tmo_irq_r <= 1'b0;
        end else if (!fifo_en || (rx_level == 7'h00)) begin
            tmo_cnt_r <= 7'h00;
            tmo_irq_r <= 1'b0;
        end else if (rx_char_push || rx_active || (rx_level >= rx_trig)) begin
            tmo_cnt_r <= 7'h00;
        end else if (bit_tick && !tmo_irq_r) begin
            if (tmo_cnt_r + 7'h01 >= tmo_limit) begin
                tmo_irq_r <= 1'b1;
            end
            tmo_cnt_r <= tmo_cnt_r + 7'h01;
        end
    end

    // Enabled pending sources, highest priority at index zero.
    assign pif.pending[SRC_LINE]  = en_eff[EN_LINE] && line_irq_r;
    assign pif.pending[SRC_RX_DATA_READY_IRQ] = en_eff[EN_RX] && rx_ready;
    assign pif.pending[SRC_RXTMO] = en_eff[EN_RX] && tmo_irq_r;
    assign pif.pending[SRC_TX]    = en_eff[EN_TX] && tx_irq_r;
    assign pif.pending[SRC_MODEM] = en_eff[EN_MODEM] && modem_irq_r;
    assign pif.pending[SRC_CHAR]  = en_eff[EN_XOFF] && (flow_char_indicator_irq_r || special_irq_r);
    assign pif.pending[SRC_FLOW]  = (en_eff[EN_FIN] && fin_irq_r) || (en_eff[EN_FOUT] && fout_irq_r);

    // Only the top source is reported; the rest stay queued.
    assign code       = pif.code;
    assign status_val = {fifo_en, fifo_en, code};

    // Interrupt line follows any enabled pending source.
    assign irq = pif.any;

endmodule : ucif_top
`default_nettype wire

/* File: hdl/ucif_pkg.sv */
// Constants for the serial channel interrupt and queue control block.
package ucif_pkg;

    // Register byte offsets on the AHB-Lite bus.
    localparam logic [7:0] OFS_ENABLE   = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_QCTRL    = 8'h08;
    localparam logic [7:0] OFS_FEATURE  = 8'h0c;
    localparam logic [7:0] OFS_FLOWCHAR = 8'h10;
    localparam logic [7:0] OFS_LINE     = 8'h14;
    localparam logic [7:0] OFS_MODEM    = 8'h18;
    localparam logic [7:0] OFS_GLOBAL   = 8'h1c;

    // Reset values.
    localparam logic [7:0] ENABLE_RST  = 8'h00;
    localparam logic [7:0] FEATURE_RST = 8'h00;

    // Enable register fields.
    localparam int EN_RX    = 0;
    localparam int EN_TX    = 1;
    localparam int EN_LINE  = 2;
    localparam int EN_MODEM = 3;
    localparam int EN_XOFF  = 5;
    localparam int EN_FOUT  = 6;
    localparam int EN_FIN   = 7;

    // Feature register fields.
    localparam int FT_TBL_LO = 0;
    localparam int FT_TBL_HI = 1;
    localparam int FT_AUTO_DIR = 2;
    localparam int FT_GATE   = 3;
    localparam int FT_AUTO_OUT = 4;
    localparam int FT_AUTO_IN  = 5;
    localparam int FT_PIN_SEL  = 6;

    // Queue control fields.
    localparam int QC_EN    = 0;
    localparam int QC_RXRST = 1;
    localparam int QC_TXRST = 2;
    localparam int QC_MODE  = 3;
    localparam int QC_TXT_LO = 4;
    localparam int QC_TXT_HI = 5;
    localparam int QC_RXT_LO = 6;
    localparam int QC_RXT_HI = 7;

    // Line state bits.
    localparam int LS_READY = 0;
    localparam int LS_THR_E = 5;
    localparam int LS_ALL_E = 6;

    // Receive timeout: four characters plus this many bit times.
    localparam int          TMO_CHARS = 4;
    localparam logic [6:0]  TMO_BITS  = 7'h0c;

    // Pending source index, highest priority first.
    localparam int NSRC      = 7;
    localparam int SRC_LINE  = 0;
    localparam int SRC_RX_DATA_READY_IRQ = 1;
    localparam int SRC_RXTMO = 2;
    localparam int SRC_TX    = 3;
    localparam int SRC_MODEM = 4;
    localparam int SRC_CHAR  = 5;
    localparam int SRC_FLOW  = 6;

    // Six-bit status codes per source.
    localparam logic [5:0] CODE_LINE  = 6'h06;
    localparam logic [5:0] CODE_RX_DATA_READY_IRQ = 6'h04;
    localparam logic [5:0] CODE_RXTMO = 6'h0c;
    localparam logic [5:0] CODE_TX    = 6'h02;
    localparam logic [5:0] CODE_MODEM = 6'h00;
    localparam logic [5:0] CODE_CHAR  = 6'h10;
    localparam logic [5:0] CODE_FLOW  = 6'h20;
    localparam logic [5:0] CODE_NONE  = 6'h01;

endpackage : ucif_pkg

/* File: hdl/ucif_prio_if.sv */
// Interface between the source logic and the priority encoder.
`timescale 1ns/1ps
`default_nettype none
interface ucif_prio_if;
    import ucif_pkg::*;
    logic [NSRC-1:0] pending;
    logic [5:0]      code;
    logic            any;
    modport enc (input pending, output code, output any);
    modport user (output pending, input code, input any);
endinterface : ucif_prio_if
`default_nettype wire

/* File: hdl/ucif_prio.sv */
// Priority encoder that turns pending sources into the status code.
`timescale 1ns/1ps
`default_nettype none
module ucif_prio
    import ucif_pkg::*;
(
    // Pending sources in, code out.
    ucif_prio_if.enc pif
);
    localparam logic [NSRC-1:0][5:0] CODES = {CODE_FLOW, CODE_CHAR, CODE_MODEM, CODE_TX,
                                              CODE_RXTMO, CODE_RX_DATA_READY_IRQ, CODE_LINE};

    // Lowest index wins, so scan from the lowest priority upward.
    always_comb begin
        pif.code = CODE_NONE;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pif.pending[i]) begin
                pif.code = CODES[i];
            end
        end
    end

    // Any pending source drops the no-interrupt flag.
    assign pif.any = |pif.pending;

endmodule : ucif_prio
`default_nettype wire

/* File: tb/ucif_chk.sv */
// Bus and control checks for the channel interrupt block.
`timescale 1ns/1ps
`default_nettype none
module ucif_chk
    import ucif_pkg::*;
(
    // Clock and reset.
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus.
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // Control and indications.
    input wire logic        fifo_en,
    input wire logic        rx_fifo_reset,
    input wire logic        tx_fifo_reset,
    input wire logic        sleep_active,
    input wire logic        wake_ind,
    input wire logic        irq
);
    logic       dq;
    logic       dw;
    logic [7:0] da;
    logic       rd1;
    logic       wr1;

    // Data phase tracker.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) {dq, dw, da} <= 10'h0;
        else if (hready) {dq, dw, da} <= {hsel & htrans[1], hwrite, haddr};
    end

    // First data cycle of a read, and of a queue control write.
    assign rd1 = dq && !dw && !hreadyout;
    assign wr1 = dq && dw && !hreadyout && da == OFS_QCTRL;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    wait_state_a: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
        else $error("wait state wrong");
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    status_fifo_a: assert property (rd1 && da == OFS_STATUS |=> hrdata[7:6] == {2{fifo_en}} && hrdata[31:8] == 24'h0)
        else $error("status queue bits wrong");
    status_idle_a: assert property (rd1 && da == OFS_STATUS |=> hrdata[0] == !$past(irq))
        else $error("status idle bit wrong");
    rx_reset_a: assert property (wr1 && hwdata[1:0] == 2'b11 |=> rx_fifo_reset)
        else $error("receive reset missing");
    tx_reset_a: assert property (wr1 && hwdata[2] && hwdata[0] |=> tx_fifo_reset)
        else $error("transmit reset missing");
    reset_pulse_a: assert property (rx_fifo_reset || tx_fifo_reset |=> !rx_fifo_reset && !tx_fifo_reset)
        else $error("queue reset too long");
    reset_gate_a: assert property (rx_fifo_reset || tx_fifo_reset |-> $past(wr1 && hwdata[0]))
        else $error("stray queue reset");
    queue_en_a: assert property ($changed(fifo_en) |-> $past(wr1) && fifo_en == $past(hwdata[0]))
        else $error("bad queue enable");
    wake_set_a: assert property ($fell(sleep_active) |=> wake_ind)
        else $error("wake flag not set");
    wake_clear_a: assert property ($fell(wake_ind) |-> $past(rd1 && da == OFS_GLOBAL))
        else $error("stray wake clear");

    // Main scenarios reached.
    cover property (wr1 && hwdata[1:0] == 2'b11);
    cover property ($rose(wake_ind));
    cover property ($rose(irq));
endmodule : ucif_chk

bind ucif_top ucif_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .fifo_en, .rx_fifo_reset, .tx_fifo_reset, .sleep_active, .wake_ind, .irq);
`default_nettype wire

/* File: tb/tb_top.sv */
// Testbench for the channel interrupt block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ucif_pkg::*;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rx_char_push = 0, rx_active = 0, bit_tick = 0;
    logic        xon_det = 0, xoff_det = 0, special_det = 0, flow_in_cts = 0, flow_out_rts = 0, sleep_active = 0;
    logic [7:0]  haddr = 0, line_state_reg = 0, modem_state_reg = 0;
    logic [1:0]  htrans = 0;
    logic [31:0] hwdata = 0;
    logic [6:0]  rx_level = 0, rx_trig = 7'h04;
    logic [3:0]  char_bits = 4'ha;
    wire         hready, hresp, fifo_en, rx_fifo_reset, tx_fifo_reset, block_mode, auto_dir, auto_out, auto_in;
    wire         pin_sel, wake_ind, irq;
    wire  [31:0] hrdata;
    wire  [1:0]  tx_trig_sel, rx_trig_sel, trig_table;
    int          num_errors = 0, checks_done = 0, cyc = 0;

    // Clock; slave ready loops back as bus ready.
    always #2.5 hclk = ~hclk;

    ucif_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready,
        .hreadyout(hready), .hresp, .hrdata, .line_state_reg, .modem_state_reg, .rx_char_push, .rx_active,
        .bit_tick, .char_bits, .rx_level, .rx_trig, .tx_level(7'h00), .tx_trig(7'h00), .xon_det, .xoff_det,
        .special_det, .flow_in_cts, .flow_in_dsr(1'b0), .flow_out_rts, .flow_out_dtr(1'b0), .sleep_active,
        .fifo_en, .rx_fifo_reset, .tx_fifo_reset, .block_mode, .tx_trig_sel, .rx_trig_sel, .trig_table,
        .auto_dir, .auto_out, .auto_in, .pin_sel, .wake_ind, .irq);

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Address phase, then data phase, each held until ready.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, {24'h0, d}, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(n, {24'h0, e}, q);
    endtask : rd

    // Hang guard.
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            conclude();
        end
    end

    // Main sequence.
    initial begin
        tick(2);
        hresetn <= 1'b1;
        tick(1);
        rd(OFS_ENABLE, ENABLE_RST, "enable");
        rd(OFS_FEATURE, FEATURE_RST, "feature");
        wr(OFS_STATUS, 8'hff);
        rd(OFS_STATUS, 8'h01, "status idle");
        rd(OFS_QCTRL, 8'h00, "queue control");
        rd(8'h20, 8'h00, "unmapped");
        wr(OFS_QCTRL, 8'h06);
        chk("fifo_en", 0, fifo_en);
        wr(OFS_QCTRL, 8'h3f);
        chk("block_mode", 1, block_mode);
        chk("tx_trig_sel", 0, tx_trig_sel);
        rd(OFS_STATUS, 8'hc1, "status queue on");
        wr(OFS_FEATURE, 8'h0b);
        wr(OFS_QCTRL, 8'hb1);
        chk("queue fields", 32'h77, {block_mode, tx_trig_sel, rx_trig_sel, trig_table, fifo_en});
        wr(OFS_ENABLE, 8'h0f);
        rd(OFS_ENABLE, 8'h0f, "enable");
        line_state_reg <= 8'h24;
        rx_char_push <= 1'b1;
        modem_state_reg <= 8'h01;
        rx_level <= 7'h04;
        tick(1);
        rx_char_push <= 1'b0;
        tick(2);
        rd(OFS_STATUS, {2'b11, CODE_LINE}, "status line");
        rd(OFS_LINE, 8'h24, "line state");
        rd(OFS_STATUS, {2'b11, CODE_RX_DATA_READY_IRQ}, "status rx");
        rx_level <= 7'h03;
        tick(2);
        rd(OFS_STATUS, {2'b11, CODE_TX}, "status tx");
        rd(OFS_STATUS, {2'b11, CODE_MODEM}, "status modem");
        rd(OFS_MODEM, 8'h01, "modem state");
        rd(OFS_STATUS, 8'hc1, "status cleared");
        line_state_reg <= 8'h00;
        wr(OFS_FEATURE, 8'h0c);
        wr(OFS_ENABLE, 8'h02);
        line_state_reg <= 8'h20;
        tick(3);
        chk("irq dir", 0, irq);
        line_state_reg <= 8'h60;
        tick(3);
        rd(OFS_STATUS, {2'b11, CODE_TX}, "status all empty");
        rd(OFS_STATUS, 8'hc1, "status tx read");
        wr(OFS_FEATURE, 8'h00);
        wr(OFS_ENABLE, 8'he0);
        xoff_det <= 1'b1;
        tick(1);
        xoff_det <= 1'b0;
        tick(2);
        chk("irq ungated", 0, irq);
        wr(OFS_FEATURE, 8'h08);
        wr(OFS_ENABLE, 8'he0);
        xoff_det <= 1'b1;
        tick(1);
        xoff_det <= 1'b0;
        tick(2);
        rd(OFS_STATUS, {2'b11, CODE_CHAR}, "status char");
        rd(OFS_FLOWCHAR, 8'h01, "flow char");
        rd(OFS_STATUS, 8'hc1, "status char read");
        special_det <= 1'b1;
        tick(1);
        special_det <= 1'b0;
        tick(2);
        chk("irq special", 1, irq);
        rx_char_push <= 1'b1;
        tick(1);
        rx_char_push <= 1'b0;
        tick(2);
        chk("irq next char", 0, irq);
        wr(OFS_FEATURE, 8'h38);
        chk("flow ctl", 4'hc, {auto_in, auto_out, auto_dir, pin_sel});
        for (int i = 0; i < 2; i++) begin
            if (i == 0) flow_out_rts <= 1'b1;
            else flow_in_cts <= 1'b1;
            tick(2);
            rd(OFS_STATUS, {2'b11, CODE_FLOW}, "status flow");
            rd(OFS_MODEM, 8'h01, "modem flow");
            chk("irq flow", 0, irq);
        end
        wr(OFS_ENABLE, 8'h01);
        rx_level <= 7'h01;
        bit_tick <= 1'b1;
        tick(45);
        chk("irq early", 0, irq);
        tick(15);
        rd(OFS_STATUS, {2'b11, CODE_RXTMO}, "status timeout");
        rx_level <= 7'h00;
        tick(3);
        chk("irq emptied", 0, irq);
        sleep_active <= 1'b1;
        tick(2);
        sleep_active <= 1'b0;
        tick(2);
        chk("wake", 1, wake_ind);
        rd(OFS_GLOBAL, 8'h01, "global");
        tick(1);
        chk("wake cleared", 0, wake_ind);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
